/* core/tcd_pkg.sv */
// Constants for the tape channel command decoder: function codes, field
// positions, reset values. Assumes a 16-bit data bus whose bit 0 is the MSB.
// Functional notes
// (RULE1) Each 16-bit word goes to or from tape as two bytes.
// (RULE2) Odd vertical parity written on every byte and checked on read.
// (RULE3) Output codes 09,0D,11,13,03,07,01 load address, range, configs, irq, task, control; code acks 01 but drops it.
// (RULE4) Input codes 0C,08,10,12,02,26,06,18,1A,04 return the named words.
// (RULE5) Output code 09 performs both the address load and the range load.
// (RULE6) Address load keeps 24 bits: address bus 0-7 high, data bus low.
// (RULE7) Word transfers normally; byte transfer on odd first or last byte.
// (RULE8) Address bus bit 17 at address load sets direction: one means write.
// (RULE9) Range is a positive byte count, top bit zero, decremented per transfer.
// (RULE10) Zero range then forward read acts as forward space one block.
// (RULE11) Zero range then write sets operation check, no data, no motion.
// (RULE12) Address and range residue carry into the next command.
// (RULE13) Processor writes zero to config A bits 0,1,2,5,9-15.
// (RULE14) Config A bit 3 picks even or odd parity; zero means odd.
// (RULE15) Config A bit 6 sends set-diagnostic to formatter before each task; the zero-range read space goes out without it.
// (RULE16) Config A bit 7 disables buffer; takes effect only at beginning of tape.
// (RULE17) Display shows 40 while the data buffer is disabled.
// (RULE18) Config A bit 8 selects one of two recording densities.
// (RULE19) Config B bits 0-6: maintenance, mux, address inhibit, reset, ready.
// (RULE20) Config B bit 7 without diagnostic: even bytes only, odd bit 7 as parity.
// (RULE21) Interrupt control stores 6-bit level and 10-bit channel number.
// (RULE22) With level zero no interrupt is raised or retained.
// (RULE23) Subsystem initialisation clears the interrupt level.
// (RULE24) Direction disagreeing with task sets operation check, no transfer.
package tcd_pkg;
  // ==========================================================
  // Function codes
  localparam logic [5:0] FC_OUT_ADDR = 6'h09;
  localparam logic [5:0] FC_OUT_RANGE = 6'h0d;
  localparam logic [5:0] FC_OUT_CFGA = 6'h11;
  localparam logic [5:0] FC_OUT_CFGB = 6'h13;
  localparam logic [5:0] FC_OUT_IRQ = 6'h03;
  localparam logic [5:0] FC_OUT_TASK = 6'h07;
  localparam logic [5:0] FC_OUT_CTRL = 6'h01;
  localparam logic [5:0] FC_IN_RANGE = 6'h0c;
  localparam logic [5:0] FC_IN_ADDR = 6'h08;
  localparam logic [5:0] FC_IN_CFGA = 6'h10;
  localparam logic [5:0] FC_IN_CFGB = 6'h12;
  localparam logic [5:0] FC_IN_IRQ = 6'h02;
  localparam logic [5:0] FC_IN_ID = 6'h26;
  localparam logic [5:0] FC_IN_TASK = 6'h06;
  localparam logic [5:0] FC_IN_STAT1 = 6'h18;
  localparam logic [5:0] FC_IN_STAT2 = 6'h1a;
  localparam logic [5:0] FC_IN_REV = 6'h04;
  // ==========================================================
  // Field positions (vector index; bus bit 0 is index 15)
  localparam int ADDR_DIR_IDX = 6;
  localparam int CFA_PARITY = 12;
  localparam int CFA_DIAG = 9;
  localparam int CFA_BUFDIS = 8;
  localparam int CFA_DENSITY = 7;
  localparam int CFB_MAINT1 = 15;
  localparam int CFB_MUX_HI = 14;
  localparam int CFB_MUX_LO = 12;
  localparam int CFB_ADDR_INH = 11;
  localparam int CFB_FMT_RST = 10;
  localparam int CFB_FMT_RDY = 9;
  localparam int CFB_MAINT2 = 8;
  // ==========================================================
  // Task opcodes (task bits 0-7) and reset values
  localparam logic [7:0] TASK_OP_WRITE = 8'h02;
  localparam logic [7:0] TASK_OP_READ_FWD = 8'h01;
  localparam logic [7:0] DISPLAY_BUF_OFF = 8'h40;
  localparam logic [7:0] DISPLAY_IDLE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [23:0] RST_ADDR = 24'h000000;
endpackage

/* core/tcd_decoder.sv */
// Channel-side command decoder and setup registers of a tape controller.
// Assumes commands, tape bytes and memory strobes are synchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module tcd_decoder
  import tcd_pkg::*;
#(
  parameter logic [15:0] DEVICE_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] REVISION = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic init_i,
  // Processor I/O command
  input wire logic cmd_valid_i,
  input wire logic cmd_output_i,
  input wire logic [5:0] func_code_i,
  input wire logic [23:0] addr_bus_i,
  input wire logic [15:0] data_bus_i,
  output logic cmd_ack_o,
  output logic [15:0] rd_data_o,
  // Drive status and state
  input wire logic [15:0] status1_i,
  input wire logic [15:0] status2_i,
  input wire logic bot_i,
  input wire logic formatter_ready_flag_i,
  // Task sequencing toward the formatter
  input wire logic task_done_i,
  output logic busy_o,
  output logic diag_cmd_o,
  output logic task_go_o,
  output logic space_block_o,
  output logic op_check_o,
  // Configuration outputs
  output logic parity_even_o,
  output logic density_o,
  output logic buffer_disable_o,
  output logic [7:0] display_o,
  output logic maintenance_select_one_o,
  output logic [2:0] mux_ctrl_o,
  output logic formatter_bus_address_inhibit_o,
  output logic formatter_reset_o,
  output logic maintenance_select_two_o,
  // Memory transfer bookkeeping
  input wire logic mem_xfer_i,
  output logic [23:0] mem_addr_o,
  output logic mem_byte_o,
  output logic dir_write_o,
  // Write data: word in, tape bytes out
  input wire logic wr_word_valid_i,
  input wire logic [15:0] wr_word_i,
  output logic wr_word_ready_o,
  output logic tape_byte_valid_o,
  output logic [7:0] tape_byte_o,
  output logic tape_par_o,
  // Read data: tape bytes in, word out
  input wire logic rd_byte_valid_i,
  input wire logic [7:0] rd_byte_i,
  input wire logic rd_par_i,
  output logic rd_word_valid_o,
  output logic [15:0] rd_word_o,
  output logic parity_err_o,
  // Interrupt routing
  input wire logic event_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  output logic [5:0] irq_level_o,
  output logic [9:0] irq_chan_o
);

  // ==========================================================
  // State
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_DIAG = 2'b01,
    T_RUN = 2'b10
  } tcd_task_e;

  typedef struct packed {
    tcd_task_e tst;
    logic [23:0] addr;
    logic [15:0] range;
    logic dir;
    logic [15:0] cfga;
    logic [15:0] cfgb;
    logic buf_dis;
    logic [5:0] lvl;
    logic [9:0] chan;
    logic [15:0] task_w;
    logic [15:0] rdata;
    logic ack;
    logic irq;
    logic tx_second;
    logic [7:0] tx_low;
    logic [7:0] tbyte;
    logic tpar;
    logic tvld;
    logic rx_second;
    logic [7:0] rx_high;
    logic [15:0] rword;
    logic rvld;
    logic perr;
    logic diag_go;
    logic task_go;
    logic sp_go;
    logic op_chk;
  } tcd_state_s;

  tcd_state_s st_r;
  tcd_state_s st_nxt;

  // Byte parity per the configured sense; odd unless bit 3 asks for even
  function automatic logic par_of(input logic [7:0] b, input logic even);
    par_of = even ? ^b : ~^b;
  endfunction

  logic out_cmd;
  logic [7:0] opcode;
  logic is_wr_task;
  logic is_rd_task;
  logic diag_on;
  logic maint2_on;
  logic byte_xfer;

  // Command decode helpers
  assign out_cmd = cmd_valid_i & cmd_output_i;
  assign opcode = data_bus_i[15:8];
  assign is_wr_task = (opcode == TASK_OP_WRITE);
  assign is_rd_task = (opcode == TASK_OP_READ_FWD);
  assign diag_on = st_r.cfga[CFA_DIAG];
  assign maint2_on = st_r.cfgb[CFB_MAINT2] & ~diag_on;
  // Odd start or a single byte left forces a byte cycle
  assign byte_xfer = st_r.addr[0] | (st_r.range == 16'h0001); // RULE7

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.diag_go = 1'b0;
    st_nxt.task_go = 1'b0;
    st_nxt.sp_go = 1'b0;
    st_nxt.op_chk = 1'b0;
    st_nxt.tvld = 1'b0;
    st_nxt.rvld = 1'b0;
    st_nxt.perr = 1'b0;

    // Output commands load the setup registers
    if (out_cmd) begin
      st_nxt.ack = 1'b1;
      case (func_code_i) // RULE3
        FC_OUT_ADDR: begin
          st_nxt.addr = {addr_bus_i[23:16], data_bus_i}; // RULE6
          st_nxt.dir = addr_bus_i[ADDR_DIR_IDX]; // RULE8
          st_nxt.range = data_bus_i; // RULE5
        end
        FC_OUT_RANGE: begin
          st_nxt.range = data_bus_i; // RULE9
        end
        FC_OUT_CFGA: begin
          // Reserved bits are stored as written; software keeps them zero
          st_nxt.cfga = data_bus_i; // RULE13
          // Buffer control only changes when the drive sits at its load point
          if (bot_i) begin
            st_nxt.buf_dis = data_bus_i[CFA_BUFDIS]; // RULE16
          end
        end
        FC_OUT_CFGB: begin
          st_nxt.cfgb = data_bus_i; // RULE19
        end
        FC_OUT_IRQ: begin
          st_nxt.lvl = data_bus_i[5:0]; // RULE21
          st_nxt.chan = data_bus_i[15:6];
        end
        FC_OUT_TASK: begin
          if (st_r.tst == T_IDLE) begin
            st_nxt.task_w = data_bus_i;
            if ((is_wr_task && !st_r.dir) || (is_rd_task && st_r.dir)) begin
              st_nxt.op_chk = 1'b1; // RULE24
            end else if (is_wr_task && st_r.range == 16'h0000) begin
              st_nxt.op_chk = 1'b1; // RULE11
            end else if (is_rd_task && st_r.range == 16'h0000) begin
              st_nxt.sp_go = 1'b1; // RULE10
              st_nxt.tst = T_RUN;
            end else if (diag_on) begin
              st_nxt.diag_go = 1'b1; // RULE15
              st_nxt.tst = T_DIAG;
            end else begin
              st_nxt.task_go = 1'b1;
              st_nxt.tst = T_RUN;
            end
          end
        end
        default: begin
          // Control word and unknown codes are acknowledged and dropped
          st_nxt.ack = 1'b1;
        end
      endcase
    end else if (cmd_valid_i) begin
      // Input commands answer one cycle later
      st_nxt.ack = 1'b1;
      case (func_code_i) // RULE4
        FC_IN_RANGE: st_nxt.rdata = st_r.range;
        FC_IN_ADDR: st_nxt.rdata = st_r.addr[15:0];
        FC_IN_CFGA: st_nxt.rdata = st_r.cfga;
        FC_IN_CFGB: begin
          st_nxt.rdata = st_r.cfgb;
          st_nxt.rdata[CFB_FMT_RDY] = formatter_ready_flag_i; // RULE19
        end
        FC_IN_IRQ: st_nxt.rdata = {st_r.chan, st_r.lvl};
        FC_IN_ID: st_nxt.rdata = DEVICE_ID;
        FC_IN_TASK: st_nxt.rdata = st_r.task_w;
        FC_IN_STAT1: st_nxt.rdata = status1_i;
        FC_IN_STAT2: st_nxt.rdata = status2_i;
        FC_IN_REV: st_nxt.rdata = REVISION;
        default: st_nxt.rdata = RST_WORD;
      endcase
    end

    // Task sequencing: diagnostic command goes out first, task next cycle
    case (st_r.tst)
      T_DIAG: begin
        st_nxt.task_go = 1'b1; // RULE15
        st_nxt.tst = T_RUN;
      end
      T_RUN: begin
        if (task_done_i) begin
          st_nxt.tst = T_IDLE;
        end
      end
      T_IDLE: begin
        // A task word decoded above may already have chosen the next state
      end
      default: st_nxt.tst = T_IDLE;
    endcase

    // Memory transfer steps address and range; residue stays for next task
    if (mem_xfer_i && st_r.range != 16'h0000) begin // RULE12
      st_nxt.addr = st_r.addr + (byte_xfer ? 24'h000001 : 24'h000002);
      st_nxt.range = st_r.range - (byte_xfer ? 16'h0001 : 16'h0002); // RULE9
    end

    // Write path: a word becomes two tape bytes, high byte first; in maintenance mode only the high byte
    if (st_r.tx_second) begin
      st_nxt.tbyte = st_r.tx_low; // RULE1
      st_nxt.tpar = par_of(st_r.tx_low, st_r.cfga[CFA_PARITY]); // RULE2 RULE14
      st_nxt.tvld = 1'b1;
      st_nxt.tx_second = 1'b0;
    end else if (wr_word_valid_i) begin
      st_nxt.tbyte = wr_word_i[15:8];
      st_nxt.tvld = 1'b1;
      if (maint2_on) begin
        // Maintenance write: odd byte bit 7 supplies the parity bit
        st_nxt.tpar = wr_word_i[0]; // RULE20
      end else begin
        st_nxt.tpar = par_of(wr_word_i[15:8], st_r.cfga[CFA_PARITY]); // RULE2
        st_nxt.tx_low = wr_word_i[7:0];
        st_nxt.tx_second = 1'b1; // RULE1
      end
    end

    // Read path: two checked bytes assemble into one word
    if (rd_byte_valid_i) begin
      st_nxt.perr = (rd_par_i != par_of(rd_byte_i, st_r.cfga[CFA_PARITY])); // RULE2
      if (st_r.rx_second) begin
        st_nxt.rword = {st_r.rx_high, rd_byte_i}; // RULE1
        st_nxt.rvld = 1'b1;
        st_nxt.rx_second = 1'b0;
      end else begin
        st_nxt.rx_high = rd_byte_i;
        st_nxt.rx_second = 1'b1;
      end
    end

    // Interrupt pending: set beats acknowledge, level zero drops it
    if (irq_ack_i) begin
      st_nxt.irq = 1'b0;
    end
    if (event_i) begin
      st_nxt.irq = 1'b1;
    end
    if (st_nxt.lvl == 6'h00) begin
      st_nxt.irq = 1'b0; // RULE22
    end

    // Initialisation clears level and re-enables the buffer
    if (init_i) begin
      st_nxt.lvl = 6'h00; // RULE23
      st_nxt.irq = 1'b0;
      st_nxt.buf_dis = 1'b0; // RULE16
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign cmd_ack_o = st_r.ack;
  assign rd_data_o = st_r.rdata;
  assign busy_o = (st_r.tst != T_IDLE);
  assign diag_cmd_o = st_r.diag_go;
  assign task_go_o = st_r.task_go;
  assign space_block_o = st_r.sp_go;
  assign op_check_o = st_r.op_chk;
  assign parity_even_o = st_r.cfga[CFA_PARITY]; // RULE14
  assign density_o = st_r.cfga[CFA_DENSITY]; // RULE18
  assign buffer_disable_o = st_r.buf_dis;
  assign display_o = st_r.buf_dis ? DISPLAY_BUF_OFF : DISPLAY_IDLE; // RULE17
  assign maintenance_select_one_o = st_r.cfgb[CFB_MAINT1] & diag_on; // RULE19
  assign mux_ctrl_o = st_r.cfgb[CFB_MUX_HI:CFB_MUX_LO];
  assign formatter_bus_address_inhibit_o = st_r.cfgb[CFB_ADDR_INH];
  assign formatter_reset_o = st_r.cfgb[CFB_FMT_RST];
  assign maintenance_select_two_o = maint2_on;
  assign mem_addr_o = st_r.addr;
  assign mem_byte_o = byte_xfer;
  assign dir_write_o = st_r.dir;
  // Second byte slot blocks a new word: that is the back-pressure
  assign wr_word_ready_o = ~st_r.tx_second;
  assign tape_byte_valid_o = st_r.tvld;
  assign tape_byte_o = st_r.tbyte;
  assign tape_par_o = st_r.tpar;
  assign rd_word_valid_o = st_r.rvld;
  assign rd_word_o = st_r.rword;
  assign parity_err_o = st_r.perr;
  assign irq_o = st_r.irq;
  assign irq_level_o = st_r.lvl;
  assign irq_chan_o = st_r.chan;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_addr_load: assert property ( // RULE6
    out_cmd && func_code_i == FC_OUT_ADDR && !mem_xfer_i |=>
      mem_addr_o == {$past(addr_bus_i[23:16]), $past(data_bus_i)})
    else $error("address load mismatch");
  chk_addr_range: assert property ( // RULE5
    out_cmd && func_code_i == FC_OUT_ADDR && !mem_xfer_i |=> st_r.range == $past(data_bus_i))
    else $error("address command did not load range");
  chk_dir_bit: assert property ( // RULE8
    out_cmd && func_code_i == FC_OUT_ADDR |=> dir_write_o == $past(addr_bus_i[ADDR_DIR_IDX]))
    else $error("direction not captured");
  chk_dir_mismatch: assert property ( // RULE24
    out_cmd && func_code_i == FC_OUT_TASK && !busy_o && is_wr_task && !dir_write_o
      |=> op_check_o && !task_go_o && !busy_o ##1 !task_go_o)
    else $error("direction mismatch not checked");
  chk_zero_write: assert property ( // RULE11
    out_cmd && func_code_i == FC_OUT_TASK && !busy_o && is_wr_task && st_r.range == 16'h0000
      |=> op_check_o && !busy_o)
    else $error("zero range write not refused");
  chk_zero_read: assert property ( // RULE10
    out_cmd && func_code_i == FC_OUT_TASK && !busy_o && is_rd_task && !dir_write_o
      && st_r.range == 16'h0000 |=> space_block_o && !task_go_o)
    else $error("zero range read not spaced");
  chk_diag_first: assert property ( // RULE15
    diag_cmd_o |-> !task_go_o ##1 task_go_o)
    else $error("diagnostic command not ahead of task");
  chk_range_step: assert property ( // RULE9
    mem_xfer_i && st_r.range != 16'h0000 && !cmd_valid_i
      |=> st_r.range == $past(st_r.range) - ($past(byte_xfer) ? 16'h0001 : 16'h0002))
    else $error("range not decremented");
  chk_two_bytes: assert property ( // RULE1
    wr_word_valid_i && wr_word_ready_o && !maint2_on |=> tape_byte_valid_o ##1 tape_byte_valid_o)
    else $error("word not split into two bytes");
  chk_odd_parity: assert property ( // RULE2
    tape_byte_valid_o && !parity_even_o && !maint2_on |-> ^{tape_byte_o, tape_par_o})
    else $error("written parity not odd");
  chk_level_zero: assert property ( // RULE22
    irq_level_o == 6'h00 |-> !irq_o)
    else $error("interrupt kept at level zero");
  chk_init_level: assert property ( // RULE23
    init_i |=> irq_level_o == 6'h00)
    else $error("init did not clear level");
  chk_display: assert property ( // RULE17
    buffer_disable_o |-> display_o == DISPLAY_BUF_OFF)
    else $error("display not showing buffer off");

  cov_diag_task: cover property (diag_cmd_o ##1 task_go_o);
  cov_space: cover property (space_block_o);
  cov_maint_write: cover property (maint2_on && tape_byte_valid_o);
  cov_irq: cover property (irq_o ##1 irq_ack_i);

endmodule
`default_nettype wire

/* testbench/tcd_cpu_model.sv */
// Processor model: issues one I/O command per call on the command bus.
// Assumes the decoder samples the bus on rising edges of core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module tcd_cpu_model (
  // Clock
  input wire logic core_clk_i,
  // Command bus toward the decoder
  output logic cmd_valid_o,
  output logic cmd_output_o,
  output logic [5:0] func_code_o,
  output logic [23:0] addr_bus_o,
  output logic [15:0] data_bus_o
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_output_o = 1'b0;
    func_code_o = 6'h00;
    addr_bus_o = 24'h0;
    data_bus_o = 16'h0;
  end

  // ==========================================================
  // One command: raised after a falling edge, held across one rising edge
  task automatic issue(input logic out, input logic [5:0] fc, input logic [23:0] a,
                       input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (out && (fc == 6'h09 || fc == 6'h0d)) begin
      v[15] = 1'b0;
    end
    if (out && fc == 6'h11) begin
      v = v & 16'h1b80;
    end
    @(negedge core_clk_i);
    cmd_valid_o = 1'b1;
    cmd_output_o = out;
    func_code_o = fc;
    addr_bus_o = a;
    data_bus_o = v;
    @(negedge core_clk_i);
    cmd_valid_o = 1'b0;
    // Released bus shows inverted values so stale data is never mistaken
    addr_bus_o = ~addr_bus_o;
    data_bus_o = ~data_bus_o;
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the tape channel command decoder.
// Assumes tcd_pkg, tcd_decoder and tcd_cpu_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tcd_pkg::*;
  typedef struct packed {logic chk; logic [15:0] val;} tcd_note_s;
  localparam logic [15:0] ID_V = 16'h2b6e; // Arbitrary value
  localparam logic [15:0] REV_V = 16'h0003; // Arbitrary value
  // ==========================================================
  // Signals
  logic core_clk_i = 1'b0, rst_i = 1'b1, bot_i = 1'b0, formatter_ready_flag_i = 1'b0;
  logic [4:0] stb = 5'h0, seen = 5'h0;
  wire logic init_i = stb[0], event_i = stb[1], irq_ack_i = stb[2];
  wire logic task_done_i = stb[3], mem_xfer_i = stb[4];
  logic [15:0] status1_i = 16'h0, status2_i = 16'h0, wr_word_i = 16'h0, rd_got;
  logic wr_word_valid_i = 1'b0, rd_byte_valid_i = 1'b0, rd_par_i = 1'b0;
  logic [7:0] rd_byte_i = 8'h0;
  wire logic cmd_valid_i, cmd_output_i;
  wire logic [5:0] func_code_i;
  wire logic [23:0] addr_bus_i;
  wire logic [15:0] data_bus_i;
  logic cmd_ack_o, busy_o, diag_cmd_o, task_go_o, space_block_o, op_check_o, parity_even_o;
  logic density_o, buffer_disable_o, maintenance_select_one_o, formatter_bus_address_inhibit_o;
  logic formatter_reset_o, maintenance_select_two_o, mem_byte_o, dir_write_o, wr_word_ready_o;
  logic tape_byte_valid_o, tape_par_o, rd_word_valid_o, parity_err_o, irq_o;
  logic [15:0] rd_data_o, rd_word_o;
  logic [7:0] display_o, tape_byte_o;
  logic [2:0] mux_ctrl_o;
  logic [23:0] mem_addr_o;
  logic [5:0] irq_level_o;
  logic [9:0] irq_chan_o;
  int n_fail = 0, check_count = 0, cyc = 0;
  tcd_note_s notes[$];
  logic [8:0] tape_log[$];

  tcd_cpu_model tcd_cpu_model_inst (.core_clk_i, .cmd_valid_o(cmd_valid_i),
    .cmd_output_o(cmd_output_i), .func_code_o(func_code_i), .addr_bus_o(addr_bus_i),
    .data_bus_o(data_bus_i));
  tcd_decoder #(.DEVICE_ID(ID_V), .REVISION(REV_V)) tcd_decoder_inst (.core_clk_i, .rst_i,
    .init_i, .cmd_valid_i, .cmd_output_i, .func_code_i, .addr_bus_i, .data_bus_i, .cmd_ack_o,
    .rd_data_o, .status1_i, .status2_i, .bot_i, .formatter_ready_flag_i, .task_done_i, .busy_o,
    .diag_cmd_o, .task_go_o, .space_block_o, .op_check_o, .parity_even_o, .density_o,
    .buffer_disable_o, .display_o, .maintenance_select_one_o, .mux_ctrl_o,
    .formatter_bus_address_inhibit_o, .formatter_reset_o, .maintenance_select_two_o,
    .mem_xfer_i, .mem_addr_o, .mem_byte_o, .dir_write_o, .wr_word_valid_i, .wr_word_i,
    .wr_word_ready_o, .tape_byte_valid_o, .tape_byte_o, .tape_par_o, .rd_byte_valid_i,
    .rd_byte_i, .rd_par_i, .rd_word_valid_o, .rd_word_o, .parity_err_o, .event_i, .irq_ack_i,
    .irq_o, .irq_level_o, .irq_chan_o);

  // ==========================================================
  // Clock
  always #50 core_clk_i = ~core_clk_i;

  // ==========================================================
  // Helpers
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic ck(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic kick(input int i);
    stb[i] = 1'b1;
    idle(1);
    stb[i] = 1'b0;
  endtask
  // Note goes in the queue before the command, so the watcher never runs dry
  task automatic cmd(input logic out, input logic [5:0] fc, input logic [23:0] a,
                     input logic [15:0] d, input logic [15:0] e);
    tcd_note_s nt;
    nt.chk = !out;
    nt.val = e;
    notes.push_back(nt);
    tcd_cpu_model_inst.issue(out, fc, a, d);
  endtask
  task automatic wr(input logic [5:0] fc, input logic [23:0] a, input logic [15:0] d);
    cmd(1'b1, fc, a, d, 16'h0);
  endtask
  task automatic rd(input logic [5:0] fc, input logic [15:0] e);
    cmd(1'b0, fc, 24'h0, 16'h0, e);
  endtask
  // Pulses may land one or two cycles late, so they are gathered first
  task automatic pulses(input logic [4:0] e);
    idle(4);
    ck({19'h0, seen}, {19'h0, e});
    seen = 5'h0;
  endtask

  // ==========================================================
  // Watcher: answers against notes, pulses into sticky flags, hang limit
  always @(negedge core_clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      stop_test();
    end
    seen = seen | {task_go_o, op_check_o, space_block_o, diag_cmd_o, parity_err_o};
    if (tape_byte_valid_o) tape_log.push_back({tape_par_o, tape_byte_o});
    if (rd_word_valid_o) rd_got = rd_word_o;
    if (cmd_ack_o) begin
      if (notes.size() == 0) begin
        ck(24'h1, 24'h0);
      end else begin
        if (notes[0].chk) ck({8'h0, rd_data_o}, {8'h0, notes[0].val});
        void'(notes.pop_front());
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [23:0] a;
    logic [15:0] d, c, w;
    logic [7:0] b;
    logic [5:0] zc[6];
    zc = '{FC_IN_RANGE, FC_IN_ADDR, FC_IN_CFGA, FC_IN_CFGB, FC_IN_IRQ, 6'h3f};
    status1_i = 16'($urandom(32'hf8d04fc3));
    status2_i = 16'($urandom);
    idle(8);
    rst_i = 1'b0;
    for (int i = 0; i < 6; i++) rd(zc[i], 16'h0);
    rd(FC_IN_ID, ID_V);
    rd(FC_IN_REV, REV_V);
    rd(FC_IN_STAT1, status1_i);
    rd(FC_IN_STAT2, status2_i);
    a = 24'($urandom) | 24'h000040;
    d = (16'($urandom) & 16'h7ff8) | 16'h0004;
    wr(FC_OUT_ADDR, a, d);
    idle(2);
    ck(mem_addr_o, {a[23:16], d});
    ck({23'h0, dir_write_o}, 24'h1);
    rd(FC_IN_ADDR, d);
    rd(FC_IN_RANGE, d);
    // Buffer disable asked away from beginning of tape must not take
    c = (16'($urandom) & 16'h1a80) | 16'h0100;
    wr(FC_OUT_CFGA, 24'h0, c);
    rd(FC_IN_CFGA, c);
    ck({22'h0, parity_even_o, density_o}, {22'h0, c[12], c[7]});
    ck({15'h0, buffer_disable_o, display_o}, 24'h0);
    bot_i = 1'b1;
    wr(FC_OUT_CFGA, 24'h0, c);
    idle(2);
    ck({15'h0, buffer_disable_o, display_o}, {15'h0, 1'b1, DISPLAY_BUF_OFF});
    bot_i = 1'b0;
    wr(FC_OUT_CFGA, 24'h0, c & 16'hfeff);
    idle(2);
    ck({23'h0, buffer_disable_o}, 24'h1);
    kick(0);
    idle(2);
    ck({15'h0, buffer_disable_o, display_o}, 24'h0);
    formatter_ready_flag_i = 1'b1;
    d = 16'($urandom);
    wr(FC_OUT_CFGB, 24'h0, d);
    rd(FC_IN_CFGB, d | 16'h0200);
    ck({17'h0, maintenance_select_one_o, mux_ctrl_o, formatter_bus_address_inhibit_o,
        formatter_reset_o, maintenance_select_two_o},
       {17'h0, d[15] & c[9], d[14:12], d[11], d[10], d[8] & ~c[9]});
    wr(FC_OUT_CFGB, 24'h0, 16'h0);
    // Interrupts: silent at level zero, routed otherwise, cleared by init
    wr(FC_OUT_IRQ, 24'h0, 16'h0);
    kick(1);
    idle(2);
    ck({23'h0, irq_o}, 24'h0);
    d = 16'($urandom) | 16'h0001;
    wr(FC_OUT_IRQ, 24'h0, d);
    rd(FC_IN_IRQ, d);
    kick(1);
    idle(2);
    ck({7'h0, irq_o, irq_chan_o, irq_level_o}, {7'h0, 1'b1, d});
    kick(2);
    idle(2);
    ck({23'h0, irq_o}, 24'h0);
    kick(0);
    rd(FC_IN_IRQ, {d[15:6], 6'h0});
    // Task words: direction clash, zero range on write and read
    wr(FC_OUT_CFGA, 24'h0, 16'h0);
    seen = 5'h0;
    wr(FC_OUT_TASK, 24'h0, {TASK_OP_READ_FWD, 8'h0});
    pulses(5'b01000);
    ck({23'h0, busy_o}, 24'h0);
    wr(FC_OUT_RANGE, 24'h0, 16'h0);
    wr(FC_OUT_TASK, 24'h0, {TASK_OP_WRITE, 8'h0});
    pulses(5'b01000);
    wr(FC_OUT_ADDR, 24'h0, 16'h0);
    wr(FC_OUT_TASK, 24'h0, {TASK_OP_READ_FWD, 8'h0});
    pulses(5'b00100);
    kick(3);
    wr(FC_OUT_TASK, 24'h0, {TASK_OP_WRITE, 8'h0});
    pulses(5'b01000);
    // Diagnostic write of one word, then one memory transfer
    wr(FC_OUT_CFGA, 24'h0, 16'h0200);
    wr(FC_OUT_ADDR, 24'h000040, 16'h0004);
    wr(FC_OUT_TASK, 24'h0, {TASK_OP_WRITE, 8'h0});
    pulses(5'b10010);
    ck({22'h0, busy_o, mem_byte_o}, 24'h2);
    w = 16'($urandom);
    wr_word_i = w;
    wr_word_valid_i = 1'b1;
    while (wr_word_ready_o !== 1'b1) idle(1);
    idle(1);
    ck({23'h0, wr_word_ready_o}, 24'h0);
    wr_word_valid_i = 1'b0;
    idle(3);
    ck({15'h0, tape_log[0]}, {15'h0, ~^w[15:8], w[15:8]});
    ck({15'h0, tape_log[1]}, {15'h0, ~^w[7:0], w[7:0]});
    kick(4);
    idle(1);
    ck(mem_addr_o, 24'h000006);
    rd(FC_IN_RANGE, 16'h0002);
    kick(3);
    idle(2);
    ck({23'h0, busy_o}, 24'h0);
    rd(FC_IN_ADDR, 16'h0006);
    // Read: good high byte, low byte with broken parity
    b = 8'($urandom);
    rd_byte_i = b;
    rd_par_i = ~^b;
    rd_byte_valid_i = 1'b1;
    idle(1);
    rd_byte_i = ~b;
    rd_par_i = ^b;
    idle(1);
    rd_byte_valid_i = 1'b0;
    pulses(5'b00001);
    ck({8'h0, rd_got}, {8'h0, b, ~b});
    // Maintenance write: one byte per word, parity taken from the odd byte
    wr(FC_OUT_CFGA, 24'h0, 16'h0);
    wr(FC_OUT_CFGB, 24'h0, 16'h0100);
    w = 16'($urandom);
    wr_word_i = w;
    wr_word_valid_i = 1'b1;
    idle(1);
    wr_word_valid_i = 1'b0;
    idle(3);
    ck({15'h0, tape_log[2]}, {15'h0, w[0], w[15:8]});
    ck(24'(tape_log.size()), 24'h3);
    stop_test();
  end
endmodule
`default_nettype wire
